// ---- rtl/wim_pkg.sv ----
package wim_pkg;

    // =========================================================================
    // Clock and filter timing
    // =========================================================================
    localparam int unsigned CLK_FREQ_MHZ     = 125;
    localparam int unsigned FILT_MIN_US      = 10;
    localparam int unsigned FILT_MAX_US      = 25;
    // Accept after the least time so the 10 us window is always covered
    localparam int unsigned FILT_MIN_CYCLES  = FILT_MIN_US * CLK_FREQ_MHZ;
    localparam int unsigned FILT_MAX_CYCLES  = FILT_MAX_US * CLK_FREQ_MHZ;
    localparam int unsigned FILT_CNT_W       = 12;

    // =========================================================================
    // Register map (byte addresses)
    // =========================================================================
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CL = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;

    // CTRL fields
    localparam int unsigned CTRL_WAKE_EN_BIT = 0;
    localparam int unsigned CTRL_MODE_LSB    = 4;
    localparam int unsigned CTRL_SLEEP_BIT   = 8;
    // STATUS fields
    localparam int unsigned ST_LEVEL_BIT     = 0;
    localparam int unsigned ST_LEVEL_VAL_BIT = 1;
    localparam int unsigned ST_MODE_LSB      = 4;
    localparam int unsigned ST_REFUSED_BIT   = 12;
    // IRQ fields: bit 0 rising edge, bit 1 falling edge
    localparam int unsigned IRQ_RISE_BIT     = 0;
    localparam int unsigned IRQ_FALL_BIT     = 1;

    localparam logic        CTRL_WAKE_EN_RST = 1'b0;
    localparam logic [1:0]  IRQ_EN_RST       = 2'h0;

    // =========================================================================
    // Chip power modes
    // =========================================================================
    typedef enum logic [5:0] {
        WIM_MODE_NORMAL   = 6'h01,
        WIM_MODE_STOP     = 6'h02,
        WIM_MODE_SLEEP    = 6'h04,
        WIM_MODE_FAILSAFE = 6'h08,
        WIM_MODE_RESTART  = 6'h10,
        WIM_MODE_FLASH    = 6'h20
    } wim_mode_e;

    // Filtered edge events from the filter
    typedef struct packed {
        logic rise;
        logic fall;
    } wim_edge_s;

endpackage

// ---- rtl/wim_filter.sv ----
`timescale 1ns/1ps

module wim_filter
    import wim_pkg::*;
#(
    parameter int unsigned FILT_CYCLES = FILT_MIN_CYCLES
) (
    // Clock and reset
    input  wire logic      i_clk,
    input  wire logic      i_reset_n,
    // Sampled pin, already synchronised
    input  wire logic      i_level,
    // Filtered result
    output logic           o_level,
    output wim_edge_s      o_edge
);

    logic [FILT_CNT_W-1:0] cnt_q;
    logic                  level_q;
    wim_edge_s             edge_q;

    // =========================================================================
    // Persistence counter
    // =========================================================================
    // A disturbance shorter than the filter time restarts the count
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_q   <= '0;
            level_q <= 1'b0;
            edge_q  <= '0;
        end else begin
            edge_q <= '0;
            if (i_level == level_q) begin
                cnt_q <= '0;
            end else if (cnt_q == FILT_CNT_W'(FILT_CYCLES - 1)) begin // R2 R13
                cnt_q       <= '0;
                level_q     <= i_level;
                edge_q.rise <= i_level;  // R1
                edge_q.fall <= !i_level; // R1
            end else begin
                cnt_q <= cnt_q + FILT_CNT_W'(1);
            end
        end
    end

    assign o_level = level_q;
    assign o_edge  = edge_q;

endmodule

// ---- rtl/wim_top.sv ----
`timescale 1ns/1ps

// How it works
// (R1) A rising or a falling change on the wake input is a wake-up event.
// (R2) A change counts only after the new level has held for the filter time (10 to 25 us).
// (R3) Software switches the wake capability on or off with the enable bit.
// (R4) Below the undervoltage off threshold every wake event is ignored.
// (R5) In Normal, Stop and Flash modes the pin level is readable in a status bit.
// (R6) With the enable bit at 1 a filtered change wakes the chip from Sleep.
// (R7) In Fail-Safe any filtered change moves the chip to Restart, enable or not.
// (R8) With enable at 1 in Normal, Stop or Flash a change sets its flag and interrupts unless masked.
// (R9) Rising and falling events have their own flags and their own masks.
// (R10) Normal may not go to Sleep while either wake flag is set.
// (R11) A flag set at the sleep command or during entry wakes the chip right after Sleep; the code refuses a sleep command whose cycle carries an event.
// (R12) The host clears both wake flags before it commands Sleep.
// (R13) The pin is synchronised to the clock and the filter time is counted in clock cycles.
module wim_top
    import wim_pkg::*;
#(
    parameter int unsigned FILT_CYCLES = FILT_MIN_CYCLES
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Wake pin and supply monitor
    input  wire logic        i_local_wake_input,
    input  wire logic        i_undervoltage_off,
    // Chip state
    output wim_mode_e        o_mode,
    output logic             o_irq
);

    // =========================================================================
    // Signals
    // =========================================================================
    logic       sync1_q;
    logic       sync2_q;
    logic       filt_level;
    wim_edge_s  filt_edge;
    wim_edge_s  evt;

    logic       wake_en_q;
    logic [1:0] irq_en_q;
    logic [1:0] flag_q;
    wim_mode_e  mode_q;
    logic       refused_q;
    logic       irq_q;
    logic [31:0] prdata_q;
    logic       pready_q;
    logic       pslverr_q;

    logic       wr_acc;
    logic       rd_acc;
    logic       any_evt;
    logic       level_vis;
    logic [1:0] clr_mask;
    logic       cmd_wr;
    logic       cmd_sleep;
    logic       sleep_req;
    logic       sleep_ok;
    logic       irq_cl_wr;
    logic       irq_en_wr;
    wim_mode_e  cmd_mode;

    // =========================================================================
    // Pin synchroniser and filter
    // =========================================================================
    // The pin is asynchronous to i_clk; only the second flop feeds the filter
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= i_local_wake_input; // R13
            sync2_q <= sync1_q;
        end
    end

    // The filter keeps running in undervoltage so its level is current when the
    // supply returns; only the events are dropped further on.
    wim_filter #(
        .FILT_CYCLES (FILT_CYCLES)
    ) u_filter (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_level   (sync2_q),
        .o_level   (filt_level),
        .o_edge    (filt_edge)
    );

    // Events vanish entirely in undervoltage
    assign evt     = i_undervoltage_off ? '0 : filt_edge; // R4
    assign any_evt = evt.rise | evt.fall;

    assign level_vis = (mode_q == WIM_MODE_NORMAL) || (mode_q == WIM_MODE_STOP)
                    || (mode_q == WIM_MODE_FLASH); // R5

    // =========================================================================
    // APB decode
    // =========================================================================
    // Register map, one 32-bit word each:
    //   CTRL    wake enable, mode request, sleep request (wins over the mode field)
    //   STATUS  filtered pin level, level valid, mode, last awake-mode CTRL write was a refused sleep request
    //   IRQ_ST  rising and falling flags, read only
    //   IRQ_CL  write ones to clear flags, reads zero
    //   IRQ_EN  one mask bit per direction
    // Zero wait states: pready follows the setup cycle and the access edge
    // commits a write. Read data is captured at setup so it stands with pready.
    assign wr_acc    = i_psel && i_penable && pready_q && i_pwrite;
    assign rd_acc    = i_psel && !i_penable;
    assign cmd_wr    = wr_acc && (i_paddr == ADDR_CTRL);
    assign irq_cl_wr = wr_acc && (i_paddr == ADDR_IRQ_CL);
    assign irq_en_wr = wr_acc && (i_paddr == ADDR_IRQ_EN);
    assign cmd_sleep = i_pwdata[CTRL_SLEEP_BIT];
    assign sleep_req = cmd_wr && cmd_sleep;
    assign clr_mask  = irq_cl_wr ? i_pwdata[1:0] : 2'h0;

    always_comb begin
        cmd_mode = mode_q;
        case (i_pwdata[CTRL_MODE_LSB +: 3])
            3'h0:    cmd_mode = WIM_MODE_NORMAL;
            3'h1:    cmd_mode = WIM_MODE_STOP;
            3'h2:    cmd_mode = WIM_MODE_FLASH;
            default: cmd_mode = mode_q;
        endcase
    end

    // Every setup is answered, mapped or not, so a bad address never hangs the bus
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= i_psel && !i_penable;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prdata_q <= 32'h0;
        end else if (rd_acc) begin
            prdata_q <= 32'h0;
            case (i_paddr)
                ADDR_CTRL: begin
                    prdata_q[CTRL_WAKE_EN_BIT] <= wake_en_q;
                end
                ADDR_STATUS: begin
                    prdata_q[ST_LEVEL_BIT]     <= level_vis & filt_level; // R5
                    prdata_q[ST_LEVEL_VAL_BIT] <= level_vis;
                    prdata_q[ST_MODE_LSB +: 6] <= mode_q;
                    prdata_q[ST_REFUSED_BIT]   <= refused_q;
                end
                ADDR_IRQ_ST: begin
                    prdata_q[1:0] <= flag_q;
                end
                ADDR_IRQ_CL: begin
                    prdata_q <= 32'h0;
                end
                ADDR_IRQ_EN: begin
                    prdata_q[1:0] <= irq_en_q;
                end
                default: begin
                    prdata_q <= 32'h0;
                end
            endcase
        end
    end

    // The error flag lives only for the access cycle, like pready
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= rd_acc && !(i_paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_IRQ_ST,
                                                    ADDR_IRQ_CL, ADDR_IRQ_EN});
        end
    end

    // =========================================================================
    // Control registers
    // =========================================================================
    // Wake enable resets low, so Sleep ignores the pin until software opts in
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wake_en_q <= CTRL_WAKE_EN_RST;
        end else if (cmd_wr) begin
            wake_en_q <= i_pwdata[CTRL_WAKE_EN_BIT]; // R3
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_en_q <= IRQ_EN_RST;
        end else if (irq_en_wr) begin
            irq_en_q <= i_pwdata[1:0]; // R9
        end
    end

    // =========================================================================
    // Direction flags
    // =========================================================================
    // Set beats clear so an edge landing on the clear write is kept. Flags arm
    // only in the awake modes with wake enabled; in Fail-Safe, and in Sleep with
    // wake enabled, the event acts on the mode instead and leaves nothing behind.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flag_q <= 2'h0;
        end else if (wake_en_q && level_vis) begin // R8
            flag_q[IRQ_RISE_BIT] <= evt.rise | (flag_q[IRQ_RISE_BIT] & ~clr_mask[IRQ_RISE_BIT]);
            flag_q[IRQ_FALL_BIT] <= evt.fall | (flag_q[IRQ_FALL_BIT] & ~clr_mask[IRQ_FALL_BIT]);
        end else begin
            flag_q <= flag_q & ~clr_mask;
        end
    end

    // One cycle behind the flags, so the pin comes straight from a flop
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flag_q & irq_en_q); // R8 R9
        end
    end

    // =========================================================================
    // Sleep gate
    // =========================================================================
    // Sleep is granted only from Normal with both flags clear and no event in
    // the command cycle; such an event refuses the command rather than risk
    // losing it. Stop and Flash refuse Sleep outright.
    assign sleep_ok = (mode_q == WIM_MODE_NORMAL) && (flag_q == 2'h0) && !any_evt; // R10

    // Only commands taken in an awake mode report their outcome
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            refused_q <= 1'b0;
        end else if (cmd_wr && level_vis) begin
            refused_q <= cmd_sleep && !sleep_ok; // R10 R12
        end
    end

    // =========================================================================
    // Chip mode
    // =========================================================================
    // Sleep entry is one cycle; a flag still set there wakes the chip straight
    // back out. Fail-Safe after reset: the first accepted change restarts.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_q <= WIM_MODE_FAILSAFE;
        end else begin
            case (mode_q)
                WIM_MODE_NORMAL, WIM_MODE_STOP, WIM_MODE_FLASH: begin
                    if (sleep_req) begin
                        if (sleep_ok) begin
                            mode_q <= WIM_MODE_SLEEP; // R10
                        end
                    end else if (cmd_wr) begin
                        mode_q <= cmd_mode;
                    end
                end
                WIM_MODE_SLEEP: begin
                    if ((wake_en_q && any_evt) || flag_q != 2'h0) begin
                        mode_q <= WIM_MODE_RESTART; // R6 R11
                    end
                end
                WIM_MODE_FAILSAFE: begin
                    if (any_evt) begin
                        mode_q <= WIM_MODE_RESTART; // R7
                    end
                end
                WIM_MODE_RESTART: begin
                    if (cmd_wr) begin
                        mode_q <= WIM_MODE_NORMAL;
                    end
                end
                default: begin
                    mode_q <= WIM_MODE_FAILSAFE;
                end
            endcase
        end
    end

    // =========================================================================
    // Outputs
    // =========================================================================
    assign o_prdata  = prdata_q;
    assign o_pready  = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_mode    = mode_q;
    assign o_irq     = irq_q;

endmodule

// ---- bench/wim_wake_src.sv ----
`timescale 1ns/1ps

// =============================================================================
// Wake switch model
// =============================================================================
module wim_wake_src (
    // Clock
    input  wire logic       i_clk,
    // Wanted level and bounce length in cycles
    input  wire logic       i_level,
    input  wire logic [3:0] i_bounce,
    // Pin
    output logic            o_pin
);
    logic       settle_q = 1'b0;
    logic [3:0] cnt_q    = 4'h0;

    // Contact bounce toggles every cycle, so no run gets near the filter time
    always @(posedge i_clk) begin
        if (i_level != settle_q) begin
            settle_q <= i_level;
            cnt_q    <= i_bounce;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    assign o_pin = (cnt_q != 4'h0) ? cnt_q[0] : settle_q;
endmodule

// ---- bench/wim_top_asserts.sv ----
`timescale 1ns/1ps

// =============================================================================
// Checker
// =============================================================================
module wim_top_chk
    import wim_pkg::*;
#(
    parameter int unsigned FILT_CYCLES = FILT_MIN_CYCLES
) (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_local_wake_input,
    input wire logic        i_undervoltage_off,
    input wim_mode_e        o_mode,
    input wire logic        o_irq
);
    localparam int unsigned LIM = FILT_CYCLES + 8;
    logic [15:0] stab_q;
    logic [15:0] uv_q;
    logic        pin_q;
    logic        clr_wr;

    assign clr_wr = i_psel && i_penable && i_pwrite
                 && (i_paddr == ADDR_IRQ_CL || i_paddr == ADDR_IRQ_EN);

    // Saturating run lengths of a steady pin and of low supply
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stab_q <= 16'h0;
            uv_q   <= 16'h0;
            pin_q  <= 1'b0;
        end else begin
            pin_q  <= i_local_wake_input;
            stab_q <= (i_local_wake_input != pin_q) ? 16'h0 : stab_q + {15'h0, ~&stab_q};
            uv_q   <= !i_undervoltage_off ? 16'h0 : uv_q + {15'h0, ~&uv_q};
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    chk_ready_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("pready missing after setup");
    chk_ready_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    chk_slverr_data: assert property (o_pslverr && !i_pwrite |-> o_pready && o_prdata == 32'h0)
        else $error("refused read not clean");
    chk_sleep_exit: assert property (
        $past(o_mode) == WIM_MODE_SLEEP && o_mode != WIM_MODE_SLEEP
        |-> o_mode == WIM_MODE_RESTART) else $error("sleep left wrongly");
    chk_failsafe_exit: assert property (
        $past(o_mode) == WIM_MODE_FAILSAFE && o_mode != WIM_MODE_FAILSAFE
        |-> o_mode == WIM_MODE_RESTART) else $error("fail-safe left wrongly");
    chk_sleep_entry: assert property (
        o_mode == WIM_MODE_SLEEP && $past(o_mode) != WIM_MODE_SLEEP
        |-> $past(o_mode) == WIM_MODE_NORMAL) else $error("sleep entered wrongly");
    chk_filter_hold: assert property (
        (stab_q >= LIM && o_mode inside {WIM_MODE_SLEEP, WIM_MODE_FAILSAFE})[*4]
        |=> $stable(o_mode)) else $error("wake on steady pin");
    chk_uv_ignore: assert property (
        (uv_q >= LIM && o_mode inside {WIM_MODE_SLEEP, WIM_MODE_FAILSAFE})[*4]
        |=> $stable(o_mode)) else $error("wake at low supply");
    chk_irq_fall: assert property (
        $fell(o_irq) |-> $past(clr_wr, 2)) else $error("irq fell without clear");

    cov_sleep: cover property (o_mode == WIM_MODE_SLEEP);
    cov_wake: cover property ($past(o_mode) == WIM_MODE_SLEEP && o_mode == WIM_MODE_RESTART);
    cov_irq: cover property ($rose(o_irq));
endmodule

bind wim_top wim_top_chk #(.FILT_CYCLES(FILT_CYCLES)) chk_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_local_wake_input(i_local_wake_input),
    .i_undervoltage_off(i_undervoltage_off), .o_mode(o_mode), .o_irq(o_irq));

// ---- bench/wim_top_test.sv ----
`timescale 1ns/1ps

// =============================================================================
// Bench
// =============================================================================
module wim_top_test;
    import wim_pkg::*;
    localparam int unsigned FILT = 20;
    logic        i_clk;
    logic        i_reset_n;
    logic        i_psel;
    logic        i_penable;
    logic        i_pwrite;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        pin;
    logic        want;
    logic        uv;
    logic [31:0] rnd;
    wim_mode_e   o_mode;
    logic        o_irq;
    logic [32:0] notes[$];
    int          miscompares;
    int          checks_done;

    wim_top #(.FILT_CYCLES(FILT)) dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_local_wake_input(pin), .i_undervoltage_off(uv), .o_mode(o_mode), .o_irq(o_irq));
    wim_wake_src src_u (.i_clk(i_clk), .i_level(want), .i_bounce(rnd[3:0]), .o_pin(pin));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= w;
        i_paddr   <= a;
        i_pwdata  <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        // Request stands until pready is seen high at a rising edge
        do @(posedge i_clk); while (o_pready !== 1'b1);
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        notes.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask

    // Level change, then long enough for filter, bounce, flag and irq
    task automatic move(input logic v);
        @(posedge i_clk);
        want <= v;
        rnd  <= lfsr(rnd);
        repeat (FILT + 40) @(posedge i_clk);
    endtask

    task automatic wait_mode(input wim_mode_e m);
        for (int n = 0; n < 100 && o_mode !== m; n++) @(negedge i_clk);
        check("mode", o_mode, m);
    endtask

    task automatic irq_is(input logic v);
        repeat (2) @(negedge i_clk);
        check("irq", o_irq, v);
    endtask

    // Read data is taken at the same edge at which the master sees pready
    always @(posedge i_clk) begin
        if (o_pready === 1'b1 && i_psel && i_penable && !i_pwrite && notes.size() > 0)
            check("read", {o_pslverr, o_prdata}, notes.pop_front());
    end

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end

    initial begin
        i_reset_n = 1'b0;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 8'h0;
        i_pwdata = 32'h0;
        want = 1'b0;
        uv = 1'b0;
        rnd = 32'hd92c;
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        want <= 1'b1;
        repeat (FILT / 2) @(posedge i_clk);
        want <= 1'b0;
        repeat (FILT + 40) @(posedge i_clk);
        check("mode", o_mode, WIM_MODE_FAILSAFE);
        move(1'b1);
        wait_mode(WIM_MODE_RESTART);
        apb(1'b1, ADDR_CTRL, 32'h1);
        wait_mode(WIM_MODE_NORMAL);
        apb(1'b1, ADDR_IRQ_EN, 32'h1);
        rd(ADDR_IRQ_EN, 33'h1);
        rd(ADDR_STATUS, 33'h13);
        move(1'b0);
        rd(ADDR_IRQ_ST, 33'h2);
        irq_is(1'b0);
        apb(1'b1, ADDR_IRQ_EN, 32'h3);
        irq_is(1'b1);
        apb(1'b1, ADDR_CTRL, 32'h101);
        rd(ADDR_STATUS, 33'h1012);
        apb(1'b1, ADDR_IRQ_CL, 32'h3);
        irq_is(1'b0);
        rd(ADDR_IRQ_ST, 33'h0);
        apb(1'b1, ADDR_CTRL, 32'h101);
        wait_mode(WIM_MODE_SLEEP);
        move(1'b1);
        wait_mode(WIM_MODE_RESTART);
        apb(1'b1, ADDR_CTRL, 32'h1);
        uv <= 1'b1;
        move(1'b0);
        rd(ADDR_IRQ_ST, 33'h0);
        uv <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h10);
        wait_mode(WIM_MODE_STOP);
        move(1'b1);
        rd(ADDR_IRQ_ST, 33'h0);
        apb(1'b1, ADDR_CTRL, 32'h21);
        wait_mode(WIM_MODE_FLASH);
        rd(8'h20, {1'b1, 32'h0});
        apb(1'b1, 8'h24, rnd);
        // Second reset at low supply with the pin held high: the reset level of
        // the filter makes a rising event, which must be dropped
        uv        <= 1'b1;
        i_reset_n <= 1'b0;
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (FILT + 40) @(posedge i_clk);
        check("mode", o_mode, WIM_MODE_FAILSAFE);
        uv <= 1'b0;
        print_verdict();
    end
endmodule
